// File: rtl/mtk_pkg.sv
// Purpose: constants and types for the modem transmit keying sequencer
// Assumes: 20 MHz pclk, APB slave with 32-bit data
// Notes: delays are kept as whole milliseconds
// How it works
// - three delays, 0 to 2000 ms, 1 ms steps
// - delays exchanged as +####.## text, kept nonvolatile
// - polarity command saves polarity, enables keying
// - enabled until disable, then plain output
// - command while enabled starts pre-key delay
// - pre-key end keys output, starts warm-up
// - response sent only after warm-up ends
// - last character starts hold, output stays keyed
// - hold end unkeys, ready for next command
// - idle level low for high, high for low
// - stored keying settings apply at power-up
// - default mode disables keying and all delays
// - keying owns output bit 0 over alarms
// - tag write stores up to 16 characters
// - tag longer than 16 discarded, unchanged
// - tag read returns message, variable length
// - delay reads return stored milliseconds
// - protected commands need preceding write enable
// - successful protected command clears write enable
// - other errors keep write enable until success
// - pre-key delay starts at carriage return
package mtk_pkg;
  // ************************************
  // register byte offsets
  // ************************************
  localparam logic [7:0] MTK_CMD_OFS = 8'h00;
  localparam logic [7:0] MTK_STAT_OFS = 8'h04;
  localparam logic [7:0] MTK_DLY1_OFS = 8'h08;
  localparam logic [7:0] MTK_DLY2_OFS = 8'h0C;
  localparam logic [7:0] MTK_DLY3_OFS = 8'h10;
  localparam logic [7:0] MTK_ARG_OFS = 8'h14;
  localparam logic [7:0] MTK_TXT0_OFS = 8'h18;
  localparam logic [7:0] MTK_TAG0_OFS = 8'h28;
  localparam int MTK_TAG_WORDS = 4;
  // ************************************
  // fields and limits
  // ************************************
  localparam int MTK_CMD_LEN_LSB = 4;
  localparam int MTK_CMD_LEN_W = 5;
  localparam logic [4:0] MTK_TAG_MAX = 5'h10;
  localparam logic [10:0] MTK_DLY_MAX = 11'h7D0;
  localparam int MTK_DLY_W = 11;
  // ************************************
  // timing
  // ************************************
  localparam int MTK_CLK_NS = 50;
  localparam int MTK_TICK_NS = 1000000;
  localparam int MTK_TICK_CYC = MTK_TICK_NS / MTK_CLK_NS;
  // ************************************
  // commands and results
  // ************************************
  typedef enum logic [3:0] {
    MTK_C_NONE = 4'h0, MTK_C_WE = 4'h1, MTK_C_KEY_HI = 4'h2, MTK_C_KEY_LO = 4'h3,
    key_disable_cmd = 4'h4, MTK_C_SET1 = 4'h5, MTK_C_SET2 = 4'h6, MTK_C_SET3 = 4'h7,
    write_tag_text_cmd = 4'h8, read_pre_key_delay_cmd = 4'h9, read_warmup_delay_cmd = 4'hA,
    read_hold_delay_cmd = 4'hB, read_tag_text_cmd = 4'hC
  } mtk_cmd_t;
  typedef enum logic [1:0] {
    MTK_R_OK = 2'h0, MTK_R_WPROT = 2'h1, MTK_R_RANGE = 2'h2, MTK_R_BAD = 2'h3
  } mtk_res_t;
  typedef enum logic [4:0] {
    MTK_S_IDLE = 5'h01, MTK_S_PRE = 5'h02, MTK_S_WARM = 5'h04, MTK_S_SEND = 5'h08, MTK_S_HOLD = 5'h10
  } mtk_state_t;
  // ************************************
  // carriers
  // ************************************
  typedef struct packed {
    logic key_en;
    logic pol_high;
    logic [MTK_DLY_W-1:0] pre_key_delay;
    logic [MTK_DLY_W-1:0] warmup_delay;
    logic [MTK_DLY_W-1:0] hold_delay;
    logic [4:0] tag_len;
    logic [127:0] tag;
  } mtk_nv_t;
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } mtk_byte_t;
  localparam mtk_nv_t MTK_NV_RST = '0;
endpackage : mtk_pkg

// File: rtl/mtk_keyer.sv
// Purpose: keys a modem transmitter around each response message
// Assumes: command parser pulses cmd_cr_rx at each carriage return
// Notes: text conversion of +####.## values is done by the parser
module mtk_keyer #(
  parameter int TICK_CYC = mtk_pkg::MTK_TICK_CYC
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host command side
  input wire logic cmd_cr_rx,
  output logic host_rx_ready,
  input wire logic default_mode,
  // response stream in, serial transmitter out
  input wire mtk_pkg::mtk_byte_t resp_in,
  output logic resp_ready,
  output mtk_pkg::mtk_byte_t tx_out,
  input wire logic tx_ready,
  // digital output bit 0
  input wire logic dout0_req,
  output logic keying_output_pin,
  // nonvolatile store
  input wire mtk_pkg::mtk_nv_t nv_restore,
  output mtk_pkg::mtk_nv_t nv_image,
  output logic nv_save
);
  import mtk_pkg::*;

  // ************************************
  // state
  // ************************************
  mtk_nv_t nv_ff, nxt_nv;
  mtk_state_t st_ff, nxt_st;
  logic we_ff, nxt_we;
  logic init_ff;
  mtk_res_t res_ff, nxt_res;
  logic [3:0] last_cmd_ff;
  logic [31:0] arg_ff;
  logic [31:0] txt_ff [MTK_TAG_WORDS];
  logic [MTK_DLY_W-1:0] cnt_ff, nxt_cnt;
  logic [15:0] div_ff;
  mtk_byte_t tx_ff, nxt_tx;
  logic pin_ff, nxt_pin;
  logic save_ff;

  // ************************************
  // apb decode
  // ************************************
  wire apb_wr = psel & penable & pwrite;
  wire apb_rd_sel = psel & ~pwrite;
  wire hit_cmd = paddr == MTK_CMD_OFS;
  wire hit_stat = paddr == MTK_STAT_OFS;
  wire hit_d1 = paddr == MTK_DLY1_OFS;
  wire hit_d2 = paddr == MTK_DLY2_OFS;
  wire hit_d3 = paddr == MTK_DLY3_OFS;
  wire hit_arg = paddr == MTK_ARG_OFS;
  wire hit_txt = (paddr >= MTK_TXT0_OFS) && (paddr < MTK_TAG0_OFS) && (paddr[1:0] == 2'h0);
  wire hit_tag = (paddr >= MTK_TAG0_OFS) && (paddr < MTK_TAG0_OFS + 8'h10) && (paddr[1:0] == 2'h0);
  wire hit_any = hit_cmd | hit_stat | hit_d1 | hit_d2 | hit_d3 | hit_arg | hit_txt | hit_tag;
  wire [1:0] widx = hit_txt ? 2'(paddr - MTK_TXT0_OFS >> 2) : 2'(paddr - MTK_TAG0_OFS >> 2);
  wire cmd_go = apb_wr & hit_cmd;
  wire [3:0] cmd_code = pwdata[3:0];
  wire [4:0] cmd_len = pwdata[MTK_CMD_LEN_LSB +: MTK_CMD_LEN_W];

  // zero wait slave; unmapped gives pslverr
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  function automatic logic [31:0] dly_word(input logic [MTK_DLY_W-1:0] d);
    dly_word = {21'h0, d};
  endfunction : dly_word

  always_comb begin
    prdata = 32'h0;
    if (apb_rd_sel) begin
      if (hit_cmd) prdata = {28'h0, last_cmd_ff};
      if (hit_stat) prdata = {16'h0, nv_ff.tag_len, default_mode, st_ff, nv_ff.pol_high, nv_ff.key_en, we_ff, res_ff};
      if (hit_d1) prdata = dly_word(nv_ff.pre_key_delay);
      if (hit_d2) prdata = dly_word(nv_ff.warmup_delay);
      if (hit_d3) prdata = dly_word(nv_ff.hold_delay);
      if (hit_arg) prdata = arg_ff;
      if (hit_txt) prdata = txt_ff[widx];
      if (hit_tag) prdata = nv_ff.tag[32*widx +: 32];
    end
  end

  // ************************************
  // command execution
  // ************************************
  wire is_prot = (cmd_code >= 4'(MTK_C_KEY_HI)) && (cmd_code <= 4'(write_tag_text_cmd));
  wire is_set = (cmd_code >= 4'(MTK_C_SET1)) && (cmd_code <= 4'(MTK_C_SET3));
  wire arg_ok = arg_ff <= {21'h0, MTK_DLY_MAX};
  wire len_ok = cmd_len <= MTK_TAG_MAX;
  wire known = cmd_code != 4'(MTK_C_NONE) && cmd_code <= 4'(read_tag_text_cmd);
  logic [127:0] txt_flat;
  always_comb begin
    for (int i = 0; i < MTK_TAG_WORDS; i++) begin
      txt_flat[32*i +: 32] = txt_ff[i];
    end
  end

  always_comb begin
    nxt_nv = nv_ff;
    nxt_we = we_ff;
    nxt_res = res_ff;
    if (!init_ff) begin
      nxt_nv = nv_restore;
    end else if (cmd_go) begin
      nxt_res = MTK_R_OK;
      if (!known) begin
        nxt_res = MTK_R_BAD;
      end else if (is_prot && !we_ff) begin
        nxt_res = MTK_R_WPROT;
      end else if (is_set && !arg_ok) begin
        nxt_res = MTK_R_RANGE;
      end else if (cmd_code == 4'(write_tag_text_cmd) && !len_ok) begin
        nxt_res = MTK_R_RANGE;
      end else begin
        case (cmd_code)
          4'(MTK_C_KEY_HI), 4'(MTK_C_KEY_LO): begin
            nxt_nv.key_en = 1'b1;
            nxt_nv.pol_high = cmd_code == 4'(MTK_C_KEY_HI);
          end
          4'(key_disable_cmd): nxt_nv.key_en = 1'b0;
          4'(MTK_C_SET1): nxt_nv.pre_key_delay = arg_ff[MTK_DLY_W-1:0];
          4'(MTK_C_SET2): nxt_nv.warmup_delay = arg_ff[MTK_DLY_W-1:0];
          4'(MTK_C_SET3): nxt_nv.hold_delay = arg_ff[MTK_DLY_W-1:0];
          4'(write_tag_text_cmd): begin
            nxt_nv.tag = txt_flat;
            nxt_nv.tag_len = cmd_len;
          end
          default: ;
        endcase
      end
      if (known && cmd_code == 4'(MTK_C_WE)) nxt_we = 1'b1;
      else if (nxt_res == MTK_R_OK || nxt_res == MTK_R_WPROT) nxt_we = 1'b0;
    end
  end

  wire do_save = init_ff && cmd_go && is_prot && we_ff && nxt_res == MTK_R_OK;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_ff <= MTK_NV_RST;
      we_ff <= 1'b0;
      res_ff <= MTK_R_OK;
      init_ff <= 1'b0;
      save_ff <= 1'b0;
    end else begin
      nv_ff <= nxt_nv;
      we_ff <= nxt_we;
      res_ff <= nxt_res;
      init_ff <= 1'b1;
      save_ff <= do_save;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_cmd_ff <= 4'h0;
      arg_ff <= 32'h0;
      for (int i = 0; i < MTK_TAG_WORDS; i++) txt_ff[i] <= 32'h0;
    end else if (apb_wr) begin
      if (hit_cmd) last_cmd_ff <= cmd_code;
      if (hit_arg) arg_ff <= pwdata;
      if (hit_txt) txt_ff[widx] <= pwdata;
    end
  end

  assign nv_image = nv_ff;
  assign nv_save = save_ff;

  // ************************************
  // keying sequencer
  // ************************************
  // default mode shuts keying off
  wire seq_on = nv_ff.key_en & ~default_mode & init_ff;
  wire tick = div_ff == 16'(TICK_CYC - 1);
  wire cnt_zero = cnt_ff == '0;
  wire tx_take = tx_ff.valid & tx_ready;
  wire tx_done_last = tx_take & tx_ff.last;
  wire in_send = st_ff == MTK_S_SEND;
  wire pass = seq_on ? in_send : 1'b1;
  assign resp_ready = pass & (~tx_ff.valid | tx_ready);
  wire resp_take = resp_in.valid & resp_ready;
  assign host_rx_ready = st_ff == MTK_S_IDLE;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    case (st_ff)
      MTK_S_IDLE: begin
        if (seq_on && cmd_cr_rx) begin
          nxt_st = MTK_S_PRE;
          nxt_cnt = nv_ff.pre_key_delay;
        end
      end
      MTK_S_PRE: begin
        if (cnt_zero) begin
          nxt_st = MTK_S_WARM;
          nxt_cnt = nv_ff.warmup_delay;
        end
      end
      MTK_S_WARM: if (cnt_zero) nxt_st = MTK_S_SEND;
      MTK_S_SEND: begin
        if (tx_done_last) begin
          nxt_st = MTK_S_HOLD;
          nxt_cnt = nv_ff.hold_delay;
        end
      end
      MTK_S_HOLD: if (cnt_zero) nxt_st = MTK_S_IDLE;
      default: nxt_st = MTK_S_IDLE;
    endcase
    if (nxt_st == st_ff && !cnt_zero && tick) nxt_cnt = cnt_ff - 1'b1;
    if (!seq_on) nxt_st = MTK_S_IDLE;
  end

  always_comb begin
    nxt_tx = tx_ff;
    if (tx_take) nxt_tx.valid = 1'b0;
    if (resp_take) nxt_tx = resp_in;
  end

  wire key_act = st_ff == MTK_S_WARM || st_ff == MTK_S_SEND || st_ff == MTK_S_HOLD;
  wire key_level = key_act ? nv_ff.pol_high : ~nv_ff.pol_high;
  assign nxt_pin = seq_on ? key_level : dout0_req;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 16'h0;
    end else if (nxt_st != st_ff || tick) begin
      div_ff <= 16'h0;
    end else begin
      div_ff <= div_ff + 16'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= MTK_S_IDLE;
      cnt_ff <= '0;
      tx_ff <= '0;
      pin_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      tx_ff <= nxt_tx;
      pin_ff <= nxt_pin;
    end
  end

  assign tx_out = tx_ff;
  assign keying_output_pin = pin_ff;

  // ************************************
  // assertions
  // ************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [15:0] gap_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_ff <= 16'h0;
    end else if (nxt_st != st_ff || nxt_cnt != cnt_ff) begin
      gap_ff <= 16'h0;
    end else begin
      gap_ff <= gap_ff + 16'h1;
    end
  end

  AST_IDLE_LEVEL: assert property (
    seq_on && st_ff == MTK_S_IDLE && $past(st_ff) == MTK_S_IDLE && $past(seq_on)
      |-> keying_output_pin == ~$past(nv_ff.pol_high))
    else $error("idle keying level wrong");
  AST_CR_START: assert property (
    seq_on && st_ff == MTK_S_IDLE && cmd_cr_rx |=> st_ff == MTK_S_PRE || !seq_on)
    else $error("carriage return did not start pre-key");
  AST_PRE_UNKEYED: assert property (
    st_ff == MTK_S_PRE && seq_on |=> keying_output_pin == ~nv_ff.pol_high || !seq_on)
    else $error("output keyed during pre-key");
  AST_WARM_KEYED: assert property (
    st_ff == MTK_S_WARM && seq_on |=> keying_output_pin == nv_ff.pol_high || !seq_on)
    else $error("output not keyed in warm-up");
  AST_NO_EARLY_TX: assert property (
    seq_on && st_ff != MTK_S_SEND |-> !resp_ready)
    else $error("response taken before warm-up end");
  AST_ZERO_SKIP: assert property (
    st_ff == MTK_S_PRE && cnt_zero && seq_on |=> st_ff != MTK_S_PRE)
    else $error("zero delay stalled");
  AST_TICK_PERIOD: assert property (
    nxt_st == st_ff && nxt_cnt != cnt_ff |-> gap_ff == 16'(TICK_CYC - 1))
    else $error("delay step not one millisecond");
  AST_TICK_BOUND: assert property (
    div_ff <= 16'(TICK_CYC - 1))
    else $error("millisecond divider overran");
  AST_BUSY: assert property (
    st_ff != MTK_S_IDLE |-> !host_rx_ready)
    else $error("command accepted while sequencing");
  AST_WE_CLEAR: assert property (
    do_save |=> !we_ff && nv_save)
    else $error("write enable left after protected command");
  AST_TAG_LONG: assert property (
    init_ff && cmd_go && cmd_code == 4'(write_tag_text_cmd) && !len_ok |=> $stable(nv_ff.tag))
    else $error("overlong tag was stored");
  AST_WPROT: assert property (
    init_ff && cmd_go && is_prot && !we_ff |=> $stable(nv_ff.key_en) && res_ff == MTK_R_WPROT)
    else $error("protected command ran without enable");
  AST_DEFAULT: assert property (
    default_mode |=> keying_output_pin == $past(dout0_req) && st_ff == MTK_S_IDLE)
    else $error("keying active in default mode");
  AST_RANGE: assert property (
    init_ff |-> nv_ff.pre_key_delay <= MTK_DLY_MAX && nv_ff.warmup_delay <= MTK_DLY_MAX
      && nv_ff.hold_delay <= MTK_DLY_MAX)
    else $error("delay above limit");
  AST_HOLD_KEYED: assert property (
    st_ff == MTK_S_HOLD && seq_on |=> keying_output_pin == nv_ff.pol_high || !seq_on)
    else $error("output dropped during hold");
  AST_SEND_HOLD: assert property (
    in_send && tx_done_last && seq_on |=> st_ff == MTK_S_HOLD)
    else $error("hold not started after last character");
  AST_HOLD_END: assert property (
    st_ff == MTK_S_HOLD && cnt_zero && seq_on |=> st_ff == MTK_S_IDLE && host_rx_ready)
    else $error("hold end did not return to idle");
  AST_KEY_HI: assert property (
    do_save && cmd_code == 4'(MTK_C_KEY_HI) |=> nv_ff.key_en && nv_ff.pol_high)
    else $error("active high keying not stored");
  AST_KEY_LO: assert property (
    do_save && cmd_code == 4'(MTK_C_KEY_LO) |=> nv_ff.key_en && !nv_ff.pol_high)
    else $error("active low keying not stored");
  AST_DISABLE: assert property (
    do_save && cmd_code == 4'(key_disable_cmd) |=> !nv_ff.key_en)
    else $error("keying not disabled");
  AST_PIN_PLAIN: assert property (
    init_ff && !seq_on |=> keying_output_pin == $past(dout0_req))
    else $error("plain output not following request");
  AST_WE_KEEP: assert property (
    init_ff && cmd_go && we_ff && nxt_res == MTK_R_RANGE |=> we_ff)
    else $error("write enable lost on range error");
  AST_TAG_STORE: assert property (
    do_save && cmd_code == 4'(write_tag_text_cmd) |=> nv_ff.tag == $past(txt_flat) && nv_ff.tag_len == $past(cmd_len))
    else $error("tag text not stored");
  AST_RESTORE: assert property (
    !init_ff && presetn |=> nv_ff == $past(nv_restore))
    else $error("stored settings not restored");

  COV_FULL_CYCLE: cover property (st_ff == MTK_S_HOLD ##1 st_ff == MTK_S_IDLE);
  COV_SEND: cover property (in_send && tx_done_last);
  COV_LONG_TAG: cover property (init_ff && cmd_go && cmd_code == 4'(write_tag_text_cmd) && !len_ok);
  COV_WPROT: cover property (res_ff == MTK_R_WPROT);
  COV_ZERO_WARM: cover property (st_ff == MTK_S_WARM && cnt_zero && seq_on);
endmodule : mtk_keyer

// File: verif/mtk_modem.sv
// Purpose: modem transmitter model fed by the keyed byte stream
// Assumes: tx_out holds until tx_ready is seen high at an edge
// Notes: stalls every other cycle, like a slow serial line
module mtk_modem
  import mtk_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // keyed byte stream
  input wire mtk_pkg::mtk_byte_t tx_out,
  output logic tx_ready,
  input wire logic keying_output_pin,
  input wire logic act_lvl,
  // observation
  output int n_rx,
  output int n_cold,
  output int n_odd
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************
  // transmitter
  // ************************************
  logic stall_ff;
  // bytes are expected as 41, 42, ... restarting after each last
  logic [7:0] next_data_ff;
  assign tx_ready = stall_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_ff <= 1'b0;
      n_rx <= 0;
      n_cold <= 0;
      n_odd <= 0;
      next_data_ff <= 8'h41;
    end else begin
      stall_ff <= ~stall_ff;
      if (tx_out.valid && tx_ready) begin
        n_rx <= n_rx + 1;
        if (tx_out.data !== next_data_ff) begin
          n_odd <= n_odd + 1;
        end
        next_data_ff <= tx_out.last ? 8'h41 : next_data_ff + 8'h01;
        if (keying_output_pin !== act_lvl) begin
          n_cold <= n_cold + 1;
        end
      end
    end
  end
endmodule : mtk_modem

// File: verif/mtk_keyer_bench.sv
// Purpose: self-checking bench for the keying sequencer
// Assumes: tick shortened to 4 cycles, so 1 ms is 4 pclk
// Notes: delay windows allow a few cycles of stage slack
module mtk_keyer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import mtk_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdv;
  logic pready, pslverr, errv, host_rx_ready, resp_ready, tx_ready, keying_output_pin, nv_save;
  logic cmd_cr_rx = 0, default_mode = 0, dout0_req = 0, act_lvl = 0;
  mtk_byte_t resp_in = '0, tx_out;
  mtk_nv_t nv_restore, nv_image;
  int bad_count = 0, n_tests = 0, n_rx, n_cold, n_odd;
  always #25 pclk = ~pclk;
  mtk_keyer #(.TICK_CYC(4)) mtk_keyer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd_cr_rx(cmd_cr_rx), .host_rx_ready(host_rx_ready),
    .default_mode(default_mode), .resp_in(resp_in), .resp_ready(resp_ready), .tx_out(tx_out),
    .tx_ready(tx_ready), .dout0_req(dout0_req), .keying_output_pin(keying_output_pin),
    .nv_restore(nv_restore), .nv_image(nv_image), .nv_save(nv_save));
  mtk_modem mtk_modem_inst (.pclk(pclk), .presetn(presetn), .tx_out(tx_out), .tx_ready(tx_ready),
    .keying_output_pin(keying_output_pin), .act_lvl(act_lvl), .n_rx(n_rx), .n_cold(n_cold), .n_odd(n_odd));
  // ************************************
  // helpers
  // ************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  task automatic rng(input string n, input int lo, input int hi, input int g);
    n_tests++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("unexpected %s: expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask : rng
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cmd(input logic [3:0] c, input logic [4:0] l = 5'h0);
    apb(1'b1, MTK_CMD_OFS, {23'h0, l, c});
  endtask : cmd
  task automatic prot(input logic [3:0] c, input logic [4:0] l = 5'h0);
    cmd(MTK_C_WE);
    cmd(c, l);
  endtask : prot
  task automatic edges(input int n);
    repeat (n) @(posedge pclk);
  endtask : edges
  // ************************************
  // scenarios
  // ************************************
  task automatic t_reset();
    chk("idle pin", 32'h1, 32'(keying_output_pin));
    apb(1'b0, MTK_STAT_OFS, '0);
    chk("stat keying", 32'h1, 32'(rdv[3]));
    chk("state idle", 32'h1, 32'(rdv[9:5]));
    $display("test reset done");
  endtask : t_reset
  task automatic t_prot();
    apb(1'b1, MTK_ARG_OFS, 32'h5);
    cmd(MTK_C_SET2);
    apb(1'b0, MTK_STAT_OFS, '0);
    chk("no enable", 32'h1, 32'(rdv[1:0]));
    cmd(MTK_C_WE);
    apb(1'b1, MTK_ARG_OFS, 32'h7D1);
    cmd(MTK_C_SET2);
    apb(1'b0, MTK_STAT_OFS, '0);
    chk("range result", 32'h6, 32'(rdv[2:0]));
    apb(1'b1, MTK_ARG_OFS, 32'h7D0);
    cmd(MTK_C_SET2);
    @(posedge pclk);
    chk("nv save", 32'h1, 32'(nv_save));
    chk("nv image", 32'h7D0, 32'(nv_image.warmup_delay));
    apb(1'b0, MTK_STAT_OFS, '0);
    chk("enable cleared", 32'h0, 32'(rdv[2:0]));
    apb(1'b0, MTK_DLY2_OFS, '0);
    chk("delay max", 32'h7D0, rdv);
    apb(1'b1, MTK_ARG_OFS, 32'h0);
    prot(MTK_C_SET2);
    apb(1'b0, MTK_DLY2_OFS, '0);
    chk("delay zero", 32'h0, rdv);
    apb(1'b0, 8'h40, '0);
    chk("unmapped err", 32'h1, 32'(errv));
    $display("test protect done");
  endtask : t_prot
  task automatic t_tag();
    for (int i = 0; i < 4; i++) apb(1'b1, MTK_TXT0_OFS + 8'(4 * i), 32'hA5C30000 + i);
    prot(write_tag_text_cmd, 5'h11);
    apb(1'b0, MTK_TAG0_OFS, '0);
    chk("tag kept", 32'h0, rdv);
    prot(write_tag_text_cmd, 5'h10);
    cmd(read_tag_text_cmd);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, MTK_TAG0_OFS + 8'(4 * i), '0);
      chk("tag word", 32'hA5C30000 + i, rdv);
    end
    apb(1'b0, MTK_STAT_OFS, '0);
    chk("tag len", 32'h10, 32'(rdv[15:11]));
    $display("test tag done");
  endtask : t_tag
  task automatic t_seq(input logic act);
    int k;
    int rx0;
    rx0 = n_rx;
    act_lvl <= act;
    dout0_req <= act;
    @(posedge pclk);
    cmd_cr_rx <= 1'b1;
    @(posedge pclk);
    cmd_cr_rx <= 1'b0;
    for (k = 0; keying_output_pin !== act && k < 100; k++) @(posedge pclk);
    rng("pre-key cycles", 4, 9, k);
    chk("busy", 32'h0, 32'(host_rx_ready));
    cmd_cr_rx <= 1'b1;
    @(posedge pclk);
    cmd_cr_rx <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      resp_in <= '{valid: 1'b1, last: (i == 2), data: 8'h41 + 8'(i)};
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (resp_ready !== 1'b1 && k < 50);
      if (i == 0) rng("warm-up cycles", 1, 4, k);
    end
    resp_in <= '0;
    for (k = 0; n_rx != rx0 + 3 && k < 50; k++) @(posedge pclk);
    chk("bytes sent", 32'(rx0 + 3), 32'(n_rx));
    chk("byte order", 32'h0, 32'(n_odd));
    chk("hold keyed", 32'(act), 32'(keying_output_pin));
    for (k = 0; keying_output_pin === act && k < 100; k++) @(posedge pclk);
    rng("hold cycles", 3, 9, k);
    chk("ready again", 32'h1, 32'(host_rx_ready));
    chk("cold bytes", 32'h0, 32'(n_cold));
    edges(12);
    chk("no restart", 32'(!act), 32'(keying_output_pin));
    dout0_req <= 1'b0;
    $display("test sequence done");
  endtask : t_seq
  task automatic t_modes();
    prot(key_disable_cmd);
    dout0_req <= 1'b1;
    edges(3);
    chk("plain output", 32'h1, 32'(keying_output_pin));
    dout0_req <= 1'b0;
    edges(3);
    chk("plain output", 32'h0, 32'(keying_output_pin));
    prot(MTK_C_KEY_LO);
    default_mode <= 1'b1;
    cmd_cr_rx <= 1'b1;
    @(posedge pclk);
    cmd_cr_rx <= 1'b0;
    edges(3);
    chk("default ready", 32'h1, 32'(host_rx_ready));
    apb(1'b0, MTK_STAT_OFS, '0);
    chk("default idle", 32'h21, 32'(rdv[10:5]));
    default_mode <= 1'b0;
    $display("test modes done");
  endtask : t_modes
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize
  initial begin
    nv_restore = '{key_en: 1'b1, pol_high: 1'b0, pre_key_delay: 11'h1, warmup_delay: 11'h1,
      hold_delay: 11'h1, tag_len: 5'h0, tag: '0};
    edges(5);
    presetn <= 1'b1;
    edges(3);
    t_reset();
    t_prot();
    t_tag();
    t_seq(1'b0);
    prot(MTK_C_KEY_HI);
    edges(2);
    chk("high idle", 32'h0, 32'(keying_output_pin));
    t_seq(1'b1);
    t_modes();
    summarize();
  end
  // hang guard, far beyond the few hundred cycles of the run
  initial begin
    #1000000;
    bad_count++;
    summarize();
  end
endmodule : mtk_keyer_bench
